// *** rtl/ebwc_regs.svh ***
// constants of the byte-wide non-volatile store controller
// How it works
// (RULE1) software loads index and value before writing
// (RULE2) go without program enable starts nothing
// (RULE3) write timed by asynchronous timer oscillator
// (RULE4) hardware clears write go when done
// (RULE5) software polls go bit or takes interrupt
// (RULE6) software masks global interrupts around start
// (RULE7) program enable clear after power-on
// (RULE8) pointer high byte resets to sector zero
// (RULE9) write end sets done and shared flags
// (RULE10) vector needs all enables and free stack
// (RULE11) service clears shared flag, not done flag
// (RULE12) no idle or sleep during access
// (RULE13) keep enable and pointer cleared when idle
// (RULE14) optional read back after writing
// (RULE15) control reached via pointer 01H/040H
// (RULE16) program enable bit 3, go bit 2
// (RULE17) read: enable, go, poll, then fetch
// (RULE18) read go needs read enable; value kept
// (RULE19) never set enable and go together
// (RULE20) 256 bytes, unused index bits read zero
// (RULE21) write length counted in timer domain
`ifndef EBWC_REGS_SVH
`define EBWC_REGS_SVH
// sector-0 register addresses on the core port
`define EBWC_ADR_INDIRECT 8'h01
`define EBWC_ADR_PTR_LO 8'h02
`define EBWC_ADR_PTR_HI 8'h03
`define EBWC_ADR_INDEX 8'h10
`define EBWC_ADR_VALUE 8'h11
`define EBWC_ADR_IRQ_EN 8'h12
`define EBWC_ADR_IRQ_FLAG 8'h13
// control register location behind the pointer
`define EBWC_CTL_SECTOR 8'h01
`define EBWC_CTL_OFFSET 8'h40
// control register bit positions
`define EBWC_CTL_PEN_BIT 3
`define EBWC_CTL_PGO_BIT 2
`define EBWC_CTL_REN_BIT 1
`define EBWC_CTL_RGO_BIT 0
// interrupt enable and flag bit positions
`define EBWC_IEN_GLOBAL_BIT 0
`define EBWC_IEN_DONE_BIT 1
`define EBWC_IEN_MF_BIT 2
`define EBWC_FLG_DONE_BIT 0
`define EBWC_FLG_MF_BIT 1
// reset values and sizes
`define EBWC_RST_BYTE 8'h00
`define EBWC_INDEX_MASK 8'hFF
`define EBWC_WRITE_TICKS 8'h10
`endif

// *** rtl/ebwc_pkg.sv ***
// types of the byte-wide non-volatile store controller
`default_nettype none
package ebwc_pkg;
  // control register fields, msb first as stored
  typedef struct packed {
    logic program_enable;
    logic program_go;
    logic read_enable;
    logic read_go;
  } ebwc_ctl_t;
  // interrupt enables and request flags
  typedef struct packed {
    logic global_irq_enable;
    logic nvm_done_irq_en;
    logic mf_irq_en;
    logic nvm_done_flag;
    logic mf_flag;
  } ebwc_irq_t;
  // access sequencer states
  typedef enum logic [1:0] {
    EBWC_IDLE = 2'b00,
    EBWC_WRITE = 2'b01,
    EBWC_READ = 2'b10
  } ebwc_state_t;
endpackage : ebwc_pkg
`default_nettype wire

// *** rtl/ebwc_ctrl.sv ***
// byte-wide non-volatile store controller with core register port
`timescale 1ns/1ps
`default_nettype none
`include "ebwc_regs.svh"
module ebwc_ctrl
  import ebwc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_q,
  input wire logic timer_osc,
  input wire logic stack_full,
  output logic irq_vector_q,
  output logic write_busy_q
);

  // true when the pointer pair selects the control register
  function automatic logic ctl_selected(input logic [7:0] hi,
                                        input logic [7:0] lo);
    ctl_selected = (hi == `EBWC_CTL_SECTOR) && (lo == `EBWC_CTL_OFFSET);
  endfunction : ctl_selected

  // control register as the core reads it, reserved bits zero
  function automatic logic [7:0] ctl_byte(input ebwc_ctl_t c);
    logic [7:0] b;
    b = `EBWC_RST_BYTE;
    b[`EBWC_CTL_PEN_BIT] = c.program_enable;
    b[`EBWC_CTL_PGO_BIT] = c.program_go;
    b[`EBWC_CTL_REN_BIT] = c.read_enable;
    b[`EBWC_CTL_RGO_BIT] = c.read_go;
    ctl_byte = b;
  endfunction : ctl_byte

  // stored bytes, no reset: the content is non-volatile
  logic [7:0] mem [0:255];

  // sequencer and register state
  ebwc_state_t st_q, st_d;
  ebwc_ctl_t ctl_q, ctl_d;
  ebwc_irq_t irq_q, irq_d;
  logic [7:0] idx_q, idx_d; // cell_index_reg
  logic [7:0] val_q, val_d; // cell_value_reg
  logic [7:0] plo_q, plo_d; // pointer_low_byte
  logic [7:0] phi_q, phi_d; // pointer_high_byte
  logic [7:0] ticks_q, ticks_d; // timer ticks seen in this write
  logic [7:0] rdata_d;
  logic vec_d;
  logic busy_d; // a write cycle runs in the next cycle
  logic mem_we; // commit the value byte at write end

  // timer oscillator synchroniser and its filtered level
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic lvl_q, lvl_d;
  logic tick; // one pulse per filtered rising timer edge
  logic wr_done; // write cycle ends this cycle
  logic sel; // control register is addressed

  // three stages: the oscillator is unrelated to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= timer_osc;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // an edge counts once stages two and three agree [RULE3]
  assign tick = (osc_s2_q == osc_s3_q) && osc_s2_q && !lvl_q;
  // the timer tick count decides the end, not ref_clk [RULE21]
  assign wr_done = (st_q == EBWC_WRITE) && tick &&
                   (ticks_q == `EBWC_WRITE_TICKS - 8'h01);
  assign sel = ctl_selected(phi_q, plo_q);

  // next values of all register and sequencer state
  always_comb begin
    st_d = st_q;
    ctl_d = ctl_q;
    irq_d = irq_q;
    idx_d = idx_q;
    val_d = val_q;
    plo_d = plo_q;
    phi_d = phi_q;
    ticks_d = ticks_q;
    lvl_d = lvl_q;
    rdata_d = sfr_rdata_q;
    vec_d = 1'b0;
    mem_we = 1'b0;
    // follow the oscillator only once it is stable
    if (osc_s2_q == osc_s3_q) begin
      lvl_d = osc_s2_q;
    end
    // core writes; go bits only look at the enables already held
    if (sfr_wr) begin
      case (sfr_addr)
        `EBWC_ADR_INDEX: idx_d = sfr_wdata & `EBWC_INDEX_MASK; // [RULE20]
        `EBWC_ADR_VALUE: val_d = sfr_wdata;
        `EBWC_ADR_PTR_LO: plo_d = sfr_wdata;
        `EBWC_ADR_PTR_HI: phi_d = sfr_wdata;
        `EBWC_ADR_IRQ_EN: begin
          irq_d.global_irq_enable = sfr_wdata[`EBWC_IEN_GLOBAL_BIT];
          irq_d.nvm_done_irq_en = sfr_wdata[`EBWC_IEN_DONE_BIT];
          irq_d.mf_irq_en = sfr_wdata[`EBWC_IEN_MF_BIT];
        end
        `EBWC_ADR_IRQ_FLAG: begin
          // software clears the done flag itself [RULE11]
          irq_d.nvm_done_flag = sfr_wdata[`EBWC_FLG_DONE_BIT];
          irq_d.mf_flag = sfr_wdata[`EBWC_FLG_MF_BIT];
        end
        `EBWC_ADR_INDIRECT: begin
          // only sector 1 offset 40H reaches control [RULE15]
          if (sel) begin
            ctl_d.program_enable = sfr_wdata[`EBWC_CTL_PEN_BIT]; // [RULE16]
            ctl_d.read_enable = sfr_wdata[`EBWC_CTL_REN_BIT];
            // write start needs enable already set [RULE2] [RULE16]
            if (sfr_wdata[`EBWC_CTL_PGO_BIT] && ctl_q.program_enable &&
                !sfr_wdata[`EBWC_CTL_RGO_BIT] && st_q == EBWC_IDLE) begin
              ctl_d.program_go = 1'b1;
              ticks_d = 8'h00;
              st_d = EBWC_WRITE;
            end
            // read start likewise needs read enable [RULE18]
            if (sfr_wdata[`EBWC_CTL_RGO_BIT] && ctl_q.read_enable &&
                !sfr_wdata[`EBWC_CTL_PGO_BIT] && st_q == EBWC_IDLE) begin
              ctl_d.read_go = 1'b1;
              st_d = EBWC_READ;
            end
          end
        end
        default: ; // other addresses belong elsewhere
      endcase
    end
    // core reads; an unselected indirect port reads zero
    if (sfr_rd) begin
      case (sfr_addr)
        `EBWC_ADR_INDEX: rdata_d = idx_q;
        `EBWC_ADR_VALUE: rdata_d = val_q;
        `EBWC_ADR_PTR_LO: rdata_d = plo_q;
        `EBWC_ADR_PTR_HI: rdata_d = phi_q;
        `EBWC_ADR_IRQ_EN: begin
          rdata_d = `EBWC_RST_BYTE;
          rdata_d[`EBWC_IEN_GLOBAL_BIT] = irq_q.global_irq_enable;
          rdata_d[`EBWC_IEN_DONE_BIT] = irq_q.nvm_done_irq_en;
          rdata_d[`EBWC_IEN_MF_BIT] = irq_q.mf_irq_en;
        end
        `EBWC_ADR_IRQ_FLAG: begin
          rdata_d = `EBWC_RST_BYTE;
          rdata_d[`EBWC_FLG_DONE_BIT] = irq_q.nvm_done_flag;
          rdata_d[`EBWC_FLG_MF_BIT] = irq_q.mf_flag;
        end
        `EBWC_ADR_INDIRECT:
          rdata_d = sel ? ctl_byte(ctl_q) : `EBWC_RST_BYTE;
        default: rdata_d = `EBWC_RST_BYTE;
      endcase
    end
    // vector: all three enables, both flags, room on the stack
    if (irq_q.global_irq_enable && irq_q.nvm_done_irq_en &&
        irq_q.mf_irq_en && irq_q.nvm_done_flag && irq_q.mf_flag &&
        !stack_full && !irq_vector_q) begin // [RULE10]
      vec_d = 1'b1;
      irq_d.mf_flag = 1'b0; // only the shared flag is serviced [RULE11]
    end
    // sequencer; placed last so hardware events beat core clears
    case (st_q)
      EBWC_IDLE: ;
      EBWC_WRITE: begin
        // value register is read at the end, so hold it steady
        if (wr_done) begin
          mem_we = 1'b1;
          ctl_d.program_go = 1'b0; // [RULE4]
          irq_d.nvm_done_flag = 1'b1; // [RULE9]
          irq_d.mf_flag = 1'b1; // [RULE9]
          st_d = EBWC_IDLE;
        end else if (tick) begin
          ticks_d = ticks_q + 8'h01; // [RULE21]
        end
      end
      EBWC_READ: begin
        // fetched byte stays until the next access [RULE18]
        val_d = mem[idx_q];
        ctl_d.read_go = 1'b0;
        st_d = EBWC_IDLE;
      end
      default: st_d = EBWC_IDLE;
    endcase
    // busy follows the state that the sequencer enters
    busy_d = (st_d == EBWC_WRITE);
  end

  // register all state; power-on clears protection state [RULE7] [RULE8]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= EBWC_IDLE;
      ctl_q <= '0;
      irq_q <= '0;
      idx_q <= `EBWC_RST_BYTE;
      val_q <= `EBWC_RST_BYTE;
      plo_q <= `EBWC_RST_BYTE;
      phi_q <= `EBWC_RST_BYTE;
      ticks_q <= 8'h00;
      lvl_q <= 1'b0;
      sfr_rdata_q <= `EBWC_RST_BYTE;
      irq_vector_q <= 1'b0;
      write_busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ctl_q <= ctl_d;
      irq_q <= irq_d;
      idx_q <= idx_d;
      val_q <= val_d;
      plo_q <= plo_d;
      phi_q <= phi_d;
      ticks_q <= ticks_d;
      lvl_q <= lvl_d;
      sfr_rdata_q <= rdata_d;
      irq_vector_q <= vec_d;
      write_busy_q <= busy_d;
    end
  end

  // store commit, kept apart since the array has no reset
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[idx_q] <= val_q;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // a go write without prior enable leaves go clear
  go_needs_en_a: assert property ( // [RULE2]
    sfr_wr && sfr_addr == `EBWC_ADR_INDIRECT && sel &&
    !ctl_q.program_enable && !ctl_q.program_go |=> !ctl_q.program_go)
    else $error("write started without program enable");

  // a write lasts several clocks because the timer is slow
  write_min_len_a: assert property ( // [RULE3]
    $rose(ctl_q.program_go) |-> ctl_q.program_go [*3])
    else $error("write cycle ended too soon");

  // the go bit drops exactly one clock after the end
  go_self_clear_a: assert property ( // [RULE4]
    wr_done |=> !ctl_q.program_go && !write_busy_q)
    else $error("program go not cleared after write");

  // power-on leaves enable and pointer high byte cleared
  reset_protect_a: assert property ( // [RULE7]
    @(posedge ref_clk) $rose(rst_n) |->
      !ctl_q.program_enable && phi_q == 8'h00)
    else $error("protection state not cleared at reset");

  // write end raises both request flags
  done_flags_a: assert property ( // [RULE9]
    wr_done |=> irq_q.nvm_done_flag && irq_q.mf_flag)
    else $error("write end did not set both flags");

  // a vector only follows full enabling and free stack
  vector_cond_a: assert property ( // [RULE10]
    irq_vector_q |-> $past(irq_q.global_irq_enable) &&
      $past(irq_q.nvm_done_irq_en) && $past(irq_q.mf_irq_en) &&
      $past(irq_q.nvm_done_flag) && !$past(stack_full))
    else $error("vector without all conditions");

  // service clears the shared flag and keeps the done flag
  service_clear_a: assert property ( // [RULE11]
    irq_vector_q && !$past(wr_done) && !$past(sfr_wr) |->
      !irq_q.mf_flag && irq_q.nvm_done_flag)
    else $error("service flag handling wrong");

  // a read finishes in one clock with the stored byte
  read_fetch_a: assert property ( // [RULE18]
    st_q == EBWC_READ |=> !ctl_q.read_go && val_q == $past(mem[idx_q]))
    else $error("read did not fetch the stored byte");

  // the control byte shows only through the selected pointer
  ctl_view_a: assert property ( // [RULE15]
    sfr_rd && sfr_addr == `EBWC_ADR_INDIRECT && !sel |=>
      sfr_rdata_q == 8'h00)
    else $error("control visible without pointer select");

  write_seen_c: cover property ($rose(ctl_q.program_go) ##[1:600] wr_done);
  read_seen_c: cover property ($rose(ctl_q.read_go));
  vector_seen_c: cover property (wr_done ##[1:20] irq_vector_q);
  refused_go_c: cover property (sfr_wr && sfr_addr == `EBWC_ADR_INDIRECT &&
    sel && sfr_wdata[`EBWC_CTL_PGO_BIT] && !ctl_q.program_enable);

endmodule : ebwc_ctrl
`default_nettype wire

// *** verification/ebwc_core_model.sv ***
// core-side model: register port strobes and the write timer pin
`timescale 1ns/1ps
`default_nettype none
module ebwc_core_model (
  input wire logic ref_clk,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_q,
  output logic timer_osc
);
  // idle bus at time zero
  initial begin
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    timer_osc = 1'b0;
  end
  // free-running timer oscillator, unrelated to ref_clk
  initial begin
    #3.7;
    forever #20 timer_osc = ~timer_osc;
  end
  // one write strobe; data is scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    sfr_wdata <= ~d;
  endtask : wr
  // one read strobe; answer stands until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    d = sfr_rdata_q;
  endtask : rd
endmodule : ebwc_core_model
`default_nettype wire

// *** verification/eeprom_byte_write_ctrl_tb.sv ***
// self-checking bench of the store controller
`timescale 1ns/1ps
`default_nettype none
module eeprom_byte_write_ctrl_tb;
  logic ref_clk, rst_n, stack_full;
  logic sfr_wr, sfr_rd, timer_osc, irq_vector_q, write_busy_q;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, c, v;
  int error_cnt, n_tests, vec_base;
  int vec_cnt = 0; // vector pulses seen since time zero
  logic [7:0] idx_tab [3];
  logic [7:0] val_tab [3];
  logic [7:0] en_tab [5];
  // clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ebwc_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata_q(sfr_rdata_q), .timer_osc(timer_osc),
    .stack_full(stack_full), .irq_vector_q(irq_vector_q),
    .write_busy_q(write_busy_q));
  ebwc_core_model core (.ref_clk(ref_clk), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata_q(sfr_rdata_q), .timer_osc(timer_osc));
  // vector pulses are counted, one cycle each
  always @(posedge ref_clk) if (irq_vector_q === 1'b1) vec_cnt++;
  // compare one seen value against its expectation
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  // print counts and verdict, then stop
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  // point the pointer pair at the control register
  task automatic to_ctl;
    core.wr(8'h02, 8'h40);
    core.wr(8'h03, 8'h01);
  endtask : to_ctl
  // full write: index, value, enable, go, poll, guard again
  task automatic nv_write(input logic [7:0] i, input logic [7:0] d,
                          input logic [7:0] ie);
    int n;
    core.wr(8'h10, i);
    core.wr(8'h11, d);
    to_ctl();
    // global interrupts masked across the enable-then-go pair
    core.wr(8'h12, ie & 8'hFE);
    core.wr(8'h01, 8'h08);
    core.wr(8'h01, 8'h0C);
    @(posedge ref_clk);
    @(negedge ref_clk);
    check({7'h00, write_busy_q}, 8'h01);
    core.wr(8'h12, ie);
    n = 0;
    c = 8'h04;
    // keep polling, never idling, until the go bit drops
    while (c[2] !== 1'b0 && n < 200) begin
      core.rd(8'h01, c);
      n++;
    end
    check(c, 8'h08);
    check({7'h00, write_busy_q}, 8'h00);
    check({7'h00, n > 2}, 8'h01);
    core.wr(8'h01, 8'h00);
    core.wr(8'h03, 8'h00);
  endtask : nv_write
  // full read: enable, go, one status read, fetch from the value register
  task automatic nv_read(input logic [7:0] i, output logic [7:0] d);
    core.wr(8'h10, i);
    to_ctl();
    core.wr(8'h01, 8'h02);
    core.wr(8'h01, 8'h03);
    core.rd(8'h01, c);
    check(c, 8'h02);
    core.rd(8'h11, d);
    core.wr(8'h03, 8'h00);
  endtask : nv_read
  // watchdog sized well past the expected run
  initial begin
    #400000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    stack_full = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    void'($urandom(32'h20AF));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    // power-on state and protection
    core.rd(8'h01, c);
    check(c, 8'h00);
    core.rd(8'h10, c);
    check(c, 8'h00);
    core.rd(8'h7F, c);
    check(c, 8'h00);
    to_ctl();
    core.rd(8'h01, c);
    check(c, 8'h00);
    $display("test reset done");
    // go bits without their enables start nothing
    core.wr(8'h01, 8'h04);
    core.rd(8'h01, c);
    check(c, 8'h00);
    check({7'h00, write_busy_q}, 8'h00);
    core.wr(8'h01, 8'h01);
    core.rd(8'h01, c);
    check(c, 8'h00);
    core.wr(8'h03, 8'h00);
    $display("test refused go done");
    // boundary and random writes, flags, read back
    idx_tab = '{8'h00, 8'hFF, 8'($urandom_range(1, 254))};
    foreach (idx_tab[k]) begin
      val_tab[k] = 8'($urandom());
      nv_write(idx_tab[k], val_tab[k], 8'h00);
      core.rd(8'h13, c);
      check(c, 8'h03);
      core.wr(8'h13, 8'h00);
    end
    core.rd(8'h10, c);
    check(c, idx_tab[2]);
    foreach (idx_tab[k]) begin
      nv_read(idx_tab[k], v);
      check(v, val_tab[k]);
    end
    $display("test write and read done");
    // each missing enable or a full stack blocks the vector
    en_tab = '{8'h07, 8'h03, 8'h05, 8'h06, 8'h07};
    foreach (en_tab[k]) begin
      stack_full <= (k == 0);
      core.wr(8'h12, en_tab[k]);
      vec_base = vec_cnt;
      nv_write(8'($urandom()), 8'($urandom()), en_tab[k]);
      repeat (4) @(posedge ref_clk);
      check(8'(vec_cnt - vec_base), (k == 4) ? 8'h01 : 8'h00);
      core.rd(8'h13, c);
      check(c, (k == 4) ? 8'h01 : 8'h03);
      core.wr(8'h13, 8'h00);
    end
    $display("test interrupt done");
    close_out();
  end
endmodule : eeprom_byte_write_ctrl_tb
`default_nettype wire
